// [rtl/orc_device.sv]
// Device end: paged output regulation config bank and its mode decode
//----------------------------------------------------------------
// Contract
//----------------------------------------------------------------
// Contract
// RL1: Slew rate 16-bit, reset 9C4h, applied
// RL2: Host keeps slew within legal range
// RL3: Droop 16-bit, reset 0000h, applied
// RL4: Floor voltage reset 0000h, never undercut
// RL5: Host keeps floor within 0 to 3050mV
// RL6: Frequency 16-bit, reset 0258h, sets PWM
// RL7: Host keeps frequency 200kHz to 2MHz
// RL8: Decode mode codes 00h, 03h, 04h
// RL9: Mode resets to 03h, maximum power
// RL10: Efficiency/mfr modes: immediate decay down transitions
// RL11: Efficiency/mfr modes: phase drop always enabled
// RL12: Efficiency mode: diode emulation from bit 6
// RL13: Power mode: down transitions use turn-off settings
// RL14: Power mode: phase add/drop from bit 0
// RL15: Power mode: diode emulation from bit 28
// RL16: Mfr mode: diode emulation bit 6 or 28
// RL17: Turn-on threshold signed, reset 02BCh, gates enable
// RL18: Turn-off threshold signed, reset 01F4h, disables output
// RL19: Mode one byte, others two bytes
// RL20: Separate copy per page, page selects
// RL21: Unsupported mode codes keep active behaviour
`timescale 1ns/1ps
module orc_device #(
    parameter int PAGES = orc_pkg::ORC_PAGES
) (
    input wire logic sys_clk,
    input wire logic rst,
    orc_link_if.dev link,
    input wire logic [PAGES-1:0][31:0] loop_config,
    input wire logic [PAGES-1:0][15:0] vin_meas,
    input wire logic [PAGES-1:0][15:0] vout_target,
    output logic [PAGES-1:0][15:0] vout_regulated,
    output logic [PAGES-1:0][15:0] slew_rate_out,
    output logic [PAGES-1:0][15:0] droop_out,
    output logic [PAGES-1:0][15:0] pwm_freq_out,
    output logic [PAGES-1:0] down_decay,
    output logic [PAGES-1:0] down_toff_ctrl,
    output logic [PAGES-1:0] phase_drop_en,
    output logic [PAGES-1:0] diode_emul_en,
    output logic [PAGES-1:0] vin_ok
);
    import orc_pkg::*;

    //----------------------------------------------------------------
    // State
    //----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] slew;
        logic [15:0] droop;
        logic [15:0] floor_v;
        logic [15:0] freq;
        logic [7:0] mode;
        orc_beh_e beh;
        logic [15:0] input_turn_on_threshold;
        logic [15:0] input_turn_off_threshold;
        logic vin_ok;
        logic [15:0] vreg;
    } orc_page_s;

    typedef struct packed {
        orc_page_s [PAGES-1:0] pg;
        logic ack;
        logic nack;
        logic [15:0] rdata;
        logic busy;
    } orc_dev_s;

    orc_dev_s state_reg;
    orc_dev_s state_next;

    localparam orc_page_s PAGE_RST = '{
        slew: ORC_RST_SLEW,
        droop: ORC_RST_DROOP,
        floor_v: ORC_RST_FLOOR,
        freq: ORC_RST_FREQ,
        mode: ORC_RST_MODE,
        beh: ORC_BEH_MAX_PWR,
        input_turn_on_threshold: ORC_RST_INPUT_TURN_ON_THRESHOLD,
        input_turn_off_threshold: ORC_RST_INPUT_TURN_OFF_THRESHOLD,
        vin_ok: 1'b0,
        vreg: 16'h0000
    };

    //----------------------------------------------------------------
    // Next state
    //----------------------------------------------------------------
    always_comb begin
        logic [1:0] len;
        logic [ORC_PAGE_W-1:0] pidx;
        len = orc_cmd_len(link.cmd);
        pidx = link.page;
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.nack = 1'b0;
        // One answer per request; req must drop before next is taken
        if (!link.req) begin
            state_next.busy = 1'b0;
        end
        if (link.req && !state_reg.busy) begin
            state_next.busy = 1'b1;
            // Unmapped command or missing page: refuse, store nothing
            if (len == 2'h0 || int'(pidx) >= PAGES) begin
                state_next.nack = 1'b1;
            end else if (link.wr) begin
                state_next.ack = 1'b1;
                // RL20
                if (link.cmd == ORC_CMD_SLEW) begin
                    state_next.pg[pidx].slew = link.wdata; // RL1
                end else if (link.cmd == ORC_CMD_DROOP) begin
                    state_next.pg[pidx].droop = link.wdata; // RL3
                end else if (link.cmd == ORC_CMD_FLOOR) begin
                    state_next.pg[pidx].floor_v = link.wdata; // RL4
                end else if (link.cmd == ORC_CMD_FREQ) begin
                    state_next.pg[pidx].freq = link.wdata; // RL6
                end else if (link.cmd == ORC_CMD_MODE) begin
                    state_next.pg[pidx].mode = link.wdata[7:0]; // RL19
                    // RL8
                    if (link.wdata[7:0] == ORC_MODE_MAX_EFF) begin
                        state_next.pg[pidx].beh = ORC_BEH_MAX_EFF;
                    end else if (link.wdata[7:0] == ORC_MODE_MAX_PWR) begin
                        state_next.pg[pidx].beh = ORC_BEH_MAX_PWR;
                    end else if (link.wdata[7:0] == ORC_MODE_MFR) begin
                        state_next.pg[pidx].beh = ORC_BEH_MFR;
                    end // RL21
                end else if (link.cmd == ORC_CMD_INPUT_TURN_ON_THRESHOLD) begin
                    state_next.pg[pidx].input_turn_on_threshold = link.wdata; // RL17
                end else if (link.cmd == ORC_CMD_INPUT_TURN_OFF_THRESHOLD) begin
                    state_next.pg[pidx].input_turn_off_threshold = link.wdata; // RL18
                end
            end else begin
                state_next.ack = 1'b1;
                // Answer from the copy of the selected page
                if (link.cmd == ORC_CMD_SLEW) begin
                    state_next.rdata = state_reg.pg[pidx].slew;
                end else if (link.cmd == ORC_CMD_DROOP) begin
                    state_next.rdata = state_reg.pg[pidx].droop;
                end else if (link.cmd == ORC_CMD_FLOOR) begin
                    state_next.rdata = state_reg.pg[pidx].floor_v;
                end else if (link.cmd == ORC_CMD_FREQ) begin
                    state_next.rdata = state_reg.pg[pidx].freq;
                end else if (link.cmd == ORC_CMD_MODE) begin
                    state_next.rdata = {8'h00, state_reg.pg[pidx].mode}; // RL19
                end else if (link.cmd == ORC_CMD_INPUT_TURN_ON_THRESHOLD) begin
                    state_next.rdata = state_reg.pg[pidx].input_turn_on_threshold;
                end else begin
                    state_next.rdata = state_reg.pg[pidx].input_turn_off_threshold;
                end
            end
        end
        for (int p = 0; p < PAGES; p++) begin
            // Input hysteresis on signed thresholds
            if (!state_reg.pg[p].vin_ok && $signed(vin_meas[p]) >= $signed(state_reg.pg[p].input_turn_on_threshold)) begin
                state_next.pg[p].vin_ok = 1'b1; // RL17
            end else if (state_reg.pg[p].vin_ok &&
                         $signed(vin_meas[p]) < $signed(state_reg.pg[p].input_turn_off_threshold)) begin
                state_next.pg[p].vin_ok = 1'b0; // RL18
            end
            // Clamp target to the floor voltage
            if (vout_target[p] < state_reg.pg[p].floor_v) begin
                state_next.pg[p].vreg = state_reg.pg[p].floor_v; // RL4
            end else begin
                state_next.pg[p].vreg = vout_target[p];
            end
        end
    end

    //----------------------------------------------------------------
    // Registers
    //----------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg.pg <= {PAGES{PAGE_RST}}; // RL9
            state_reg.ack <= 1'b0;
            state_reg.nack <= 1'b0;
            state_reg.rdata <= 16'h0000;
            state_reg.busy <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    // Answers are one-cycle registered pulses
    assign link.ack = state_reg.ack;
    assign link.nack = state_reg.nack;
    assign link.rdata = state_reg.rdata;

    //----------------------------------------------------------------
    // Per-page conversion behaviour
    //----------------------------------------------------------------
    for (genvar g = 0; g < PAGES; g++) begin : g_page
        orc_beh_e beh;
        assign beh = state_reg.pg[g].beh;
        assign slew_rate_out[g] = state_reg.pg[g].slew; // RL1
        assign droop_out[g] = state_reg.pg[g].droop; // RL3
        assign pwm_freq_out[g] = state_reg.pg[g].freq; // RL6
        assign vout_regulated[g] = state_reg.pg[g].vreg; // RL4
        assign vin_ok[g] = state_reg.pg[g].vin_ok; // RL17
        assign down_decay[g] = (beh != ORC_BEH_MAX_PWR); // RL10
        assign down_toff_ctrl[g] = (beh == ORC_BEH_MAX_PWR); // RL13
        assign phase_drop_en[g] = (beh != ORC_BEH_MAX_PWR) | loop_config[g][ORC_LC_APD_BIT]; // RL11 RL14
        assign diode_emul_en[g] = (beh == ORC_BEH_MAX_EFF) ? loop_config[g][ORC_LC_DE_EFF_BIT] : // RL12
                                  (beh == ORC_BEH_MAX_PWR) ? loop_config[g][ORC_LC_DE_PWR_BIT] : // RL15
                                  (loop_config[g][ORC_LC_DE_EFF_BIT] | loop_config[g][ORC_LC_DE_PWR_BIT]); // RL16
    end
endmodule // orc_device

// [rtl/orc_host.sv]
// Host end: issues paged reads and writes, refusing out-of-range values
`timescale 1ns/1ps
module orc_host (
    input wire logic sys_clk,
    input wire logic rst,
    orc_link_if.host link,
    input wire logic usr_start,
    input wire logic usr_wr,
    input wire logic [orc_pkg::ORC_PAGE_W-1:0] usr_page,
    input wire logic [7:0] usr_cmd,
    input wire logic [15:0] usr_wdata,
    output logic usr_busy,
    output logic usr_done,
    output logic usr_err,
    output logic usr_reject,
    output logic [15:0] usr_rdata
);
    import orc_pkg::*;

    typedef enum logic [1:0] {
        ORC_H_IDLE = 2'b00,
        ORC_H_WAIT = 2'b01,
        ORC_H_DROP = 2'b10
    } orc_hst_e;

    typedef struct packed {
        orc_hst_e st;
        logic wr;
        logic [ORC_PAGE_W-1:0] page;
        logic [7:0] cmd;
        logic [15:0] wdata;
        logic done;
        logic err;
        logic reject;
        logic [15:0] rdata;
    } orc_host_s;

    orc_host_s state_reg;
    orc_host_s state_next;

    //----------------------------------------------------------------
    // Range check on values written
    //----------------------------------------------------------------
    logic legal;
    always_comb begin
        legal = 1'b1;
        if (usr_wr) begin
            if (usr_cmd == ORC_CMD_SLEW) begin
                legal = (usr_wdata >= ORC_SLEW_MIN) && (usr_wdata <= ORC_SLEW_MAX); // RL2
            end else if (usr_cmd == ORC_CMD_FLOOR) begin
                legal = (usr_wdata <= ORC_FLOOR_MAX); // RL5
            end else if (usr_cmd == ORC_CMD_FREQ) begin
                legal = (usr_wdata >= ORC_FREQ_MIN) && (usr_wdata <= ORC_FREQ_MAX); // RL7
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.err = 1'b0;
        state_next.reject = 1'b0;
        case (state_reg.st)
            ORC_H_IDLE: begin
                if (usr_start && !legal) begin
                    state_next.reject = 1'b1;
                end else if (usr_start) begin
                    state_next.st = ORC_H_WAIT;
                    state_next.wr = usr_wr;
                    state_next.page = usr_page;
                    state_next.cmd = usr_cmd;
                    // Mode command carries one byte only
                    state_next.wdata = (orc_cmd_len(usr_cmd) == 2'h1) ? {8'h00, usr_wdata[7:0]} : usr_wdata; // RL19
                end
            end
            ORC_H_WAIT: begin
                if (link.ack || link.nack) begin
                    state_next.st = ORC_H_DROP;
                    state_next.done = 1'b1;
                    state_next.err = link.nack;
                    if (link.ack && !state_reg.wr) begin
                        state_next.rdata = link.rdata;
                    end
                end
            end
            ORC_H_DROP: begin
                state_next.st = ORC_H_IDLE;
            end
            default: begin
                state_next.st = ORC_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= '{st: ORC_H_IDLE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign link.req = (state_reg.st == ORC_H_WAIT);
    assign link.wr = state_reg.wr;
    assign link.page = state_reg.page;
    assign link.cmd = state_reg.cmd;
    assign link.wdata = state_reg.wdata;
    assign usr_busy = (state_reg.st != ORC_H_IDLE);
    assign usr_done = state_reg.done;
    assign usr_err = state_reg.err;
    assign usr_reject = state_reg.reject;
    assign usr_rdata = state_reg.rdata;
endmodule // orc_host

// [rtl/orc_link_if.sv]
// Interface: parallel command link with 16-bit data words between host and config bank
`timescale 1ns/1ps
interface orc_link_if;
    logic req;
    logic wr;
    logic [orc_pkg::ORC_PAGE_W-1:0] page;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic ack;
    logic nack;
    logic [15:0] rdata;
    modport dev (input req, input wr, input page, input cmd, input wdata, output ack, output nack, output rdata);
    modport host (output req, output wr, output page, output cmd, output wdata, input ack, input nack, input rdata);
endinterface

// [rtl/orc_pkg.sv]
// Package: command codes, reset values and mode codes of the output regulation config bank
package orc_pkg;
    localparam int ORC_PAGES = 2;
    localparam int ORC_PAGE_W = 1;
    localparam logic [7:0] ORC_CMD_SLEW = 8'h27;
    localparam logic [7:0] ORC_CMD_DROOP = 8'h28;
    localparam logic [7:0] ORC_CMD_FLOOR = 8'h2B;
    localparam logic [7:0] ORC_CMD_FREQ = 8'h33;
    localparam logic [7:0] ORC_CMD_MODE = 8'h34;
    localparam logic [7:0] ORC_CMD_INPUT_TURN_ON_THRESHOLD = 8'h35;
    localparam logic [7:0] ORC_CMD_INPUT_TURN_OFF_THRESHOLD = 8'h36;
    localparam logic [15:0] ORC_RST_SLEW = 16'h09C4;
    localparam logic [15:0] ORC_RST_DROOP = 16'h0000;
    localparam logic [15:0] ORC_RST_FLOOR = 16'h0000;
    localparam logic [15:0] ORC_RST_FREQ = 16'h0258;
    localparam logic [7:0] ORC_RST_MODE = 8'h03;
    localparam logic [15:0] ORC_RST_INPUT_TURN_ON_THRESHOLD = 16'h02BC;
    localparam logic [15:0] ORC_RST_INPUT_TURN_OFF_THRESHOLD = 16'h01F4;
    localparam logic [7:0] ORC_MODE_MAX_EFF = 8'h00;
    localparam logic [7:0] ORC_MODE_MAX_PWR = 8'h03;
    localparam logic [7:0] ORC_MODE_MFR = 8'h04;
    localparam int ORC_LC_APD_BIT = 0;
    localparam int ORC_LC_DE_EFF_BIT = 6;
    localparam int ORC_LC_DE_PWR_BIT = 28;
    // Host-side legal ranges in register counts
    localparam logic [15:0] ORC_SLEW_MIN = 16'h0001;
    localparam logic [15:0] ORC_SLEW_MAX = 16'h2710;
    localparam logic [15:0] ORC_FLOOR_MAX = 16'h0BEA;
    localparam logic [15:0] ORC_FREQ_MIN = 16'h00C8;
    localparam logic [15:0] ORC_FREQ_MAX = 16'h07D0;
    typedef enum logic [1:0] {
        ORC_BEH_MAX_EFF = 2'b00,
        ORC_BEH_MAX_PWR = 2'b01,
        ORC_BEH_MFR = 2'b10
    } orc_beh_e;
    // Length in data bytes of a command, zero when unmapped
    function automatic logic [1:0] orc_cmd_len(input logic [7:0] cmd);
        logic [1:0] len;
        len = 2'h0;
        if (cmd == ORC_CMD_MODE) begin
            len = 2'h1;
        end else if (cmd == ORC_CMD_SLEW || cmd == ORC_CMD_DROOP || cmd == ORC_CMD_FLOOR ||
                     cmd == ORC_CMD_FREQ || cmd == ORC_CMD_INPUT_TURN_ON_THRESHOLD || cmd == ORC_CMD_INPUT_TURN_OFF_THRESHOLD) begin
            len = 2'h2;
        end
        return len;
    endfunction
endpackage

// [verif/orc_link_checker.sv]
// Checker: link protocol and host value range assertions
`timescale 1ns/1ps
module orc_link_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic wr,
    input wire logic [orc_pkg::ORC_PAGE_W-1:0] page,
    input wire logic [7:0] cmd,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic nack,
    input wire logic [15:0] rdata
);
    import orc_pkg::*;
    logic mapped;
    assign mapped = cmd inside {ORC_CMD_SLEW, ORC_CMD_DROOP, ORC_CMD_FLOOR, ORC_CMD_FREQ, ORC_CMD_MODE,
                                ORC_CMD_INPUT_TURN_ON_THRESHOLD, ORC_CMD_INPUT_TURN_OFF_THRESHOLD};
    logic legal_req;
    assign legal_req = mapped && (int'(page) < ORC_PAGES);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    //----------------------------------------------------------------
    // Handshake
    //----------------------------------------------------------------
    a_take_ack: assert property ($rose(req) && legal_req |=> ack && !nack)
        else $error("mapped request not acknowledged next cycle");
    a_take_nack: assert property ($rose(req) && !legal_req |=> nack && !ack)
        else $error("unmapped request not refused next cycle");
    a_answer_pulse: assert property ((ack || nack) |=> !ack && !nack)
        else $error("answer longer than one cycle");
    a_answer_with_req: assert property ((ack || nack) |-> req && $past(req))
        else $error("answer without a standing request");
    a_req_release: assert property ((ack || nack) |=> !req)
        else $error("request not dropped after answer");
    a_req_hold: assert property (req && !ack && !nack |=> req && $stable({wr, page, cmd, wdata}))
        else $error("request changed before answer");
    a_rdata_hold: assert property ($changed(rdata) |-> (ack || nack) && !wr)
        else $error("read data changed outside a read answer");
    //----------------------------------------------------------------
    // Data widths and host ranges
    //----------------------------------------------------------------
    a_mode_read_byte: assert property (ack && !wr && cmd == ORC_CMD_MODE |-> rdata[15:8] == 8'h00)
        else $error("mode read carries a second byte");
    a_mode_write_byte: assert property (req && wr && cmd == ORC_CMD_MODE |-> wdata[15:8] == 8'h00)
        else $error("mode write carries a second byte");
    a_slew_range: assert property (req && wr && cmd == ORC_CMD_SLEW |->
        wdata >= ORC_SLEW_MIN && wdata <= ORC_SLEW_MAX)
        else $error("slew write out of range");
    a_floor_range: assert property (req && wr && cmd == ORC_CMD_FLOOR |-> wdata <= ORC_FLOOR_MAX)
        else $error("floor write out of range");
    a_freq_range: assert property (req && wr && cmd == ORC_CMD_FREQ |->
        wdata >= ORC_FREQ_MIN && wdata <= ORC_FREQ_MAX)
        else $error("frequency write out of range");
endmodule // orc_link_checker

// [verif/tb.sv]
// Testbench: host and config bank joined over the link, driven through the host user port
`timescale 1ns/1ps
module tb;
    import orc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ORC_PAGES-1:0][31:0] loop_config = '0;
    logic [ORC_PAGES-1:0][15:0] vin_meas = '0;
    logic [ORC_PAGES-1:0][15:0] vout_target = '0;
    logic [ORC_PAGES-1:0][15:0] vout_regulated, slew_rate_out, droop_out, pwm_freq_out;
    logic [ORC_PAGES-1:0] down_decay, down_toff_ctrl, phase_drop_en, diode_emul_en, vin_ok;
    logic usr_start = 1'b0;
    logic usr_wr = 1'b0;
    logic [ORC_PAGE_W-1:0] usr_page = '0;
    logic [7:0] usr_cmd = '0;
    logic [15:0] usr_wdata = '0;
    logic usr_busy, usr_done, usr_err, usr_reject;
    logic [15:0] usr_rdata, got_data, last;
    logic got_err, got_rej;
    int err_count = 0;
    int checks = 0;
    logic [7:0] cmds [7] = '{ORC_CMD_SLEW, ORC_CMD_DROOP, ORC_CMD_FLOOR, ORC_CMD_FREQ, ORC_CMD_MODE,
                             ORC_CMD_INPUT_TURN_ON_THRESHOLD, ORC_CMD_INPUT_TURN_OFF_THRESHOLD};
    logic [15:0] rstv [7] = '{ORC_RST_SLEW, ORC_RST_DROOP, ORC_RST_FLOOR, ORC_RST_FREQ, {8'h00, ORC_RST_MODE},
                              ORC_RST_INPUT_TURN_ON_THRESHOLD, ORC_RST_INPUT_TURN_OFF_THRESHOLD};
    logic [7:0] wc [9] = '{ORC_CMD_SLEW, ORC_CMD_SLEW, ORC_CMD_SLEW, ORC_CMD_FREQ, ORC_CMD_FREQ, ORC_CMD_FREQ,
                           ORC_CMD_FREQ, ORC_CMD_FLOOR, ORC_CMD_FLOOR};
    logic [15:0] wd [9] = '{16'h2710, 16'h0000, 16'h2711, 16'h07D0, 16'h07D1, 16'h00C8, 16'h00C7, 16'h0BEA,
                            16'h0BEB};
    logic wj [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] modes [4] = '{ORC_MODE_MAX_EFF, ORC_MODE_MFR, 8'h05, ORC_MODE_MAX_PWR};
    logic [7:0] bmode [4] = '{ORC_MODE_MAX_EFF, ORC_MODE_MFR, ORC_MODE_MFR, ORC_MODE_MAX_PWR};
    logic [31:0] lcs [4] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0040, 32'h1000_0000};
    int vp [7] = '{0, 0, 0, 0, 0, 1, 1};
    logic [15:0] vv [7] = '{16'h0000, 16'h02BB, 16'h02BC, 16'h01F4, 16'h01F3, 16'h0000, 16'hFE0C};
    logic ve [7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

    orc_link_if link_bus ();
    orc_device #(.PAGES(ORC_PAGES)) u_orc_device (.sys_clk(sys_clk), .rst(rst), .link(link_bus.dev),
        .loop_config(loop_config), .vin_meas(vin_meas), .vout_target(vout_target),
        .vout_regulated(vout_regulated), .slew_rate_out(slew_rate_out), .droop_out(droop_out),
        .pwm_freq_out(pwm_freq_out), .down_decay(down_decay), .down_toff_ctrl(down_toff_ctrl),
        .phase_drop_en(phase_drop_en), .diode_emul_en(diode_emul_en), .vin_ok(vin_ok));
    orc_host u_orc_host (.sys_clk(sys_clk), .rst(rst), .link(link_bus.host), .usr_start(usr_start),
        .usr_wr(usr_wr), .usr_page(usr_page), .usr_cmd(usr_cmd), .usr_wdata(usr_wdata), .usr_busy(usr_busy),
        .usr_done(usr_done), .usr_err(usr_err), .usr_reject(usr_reject), .usr_rdata(usr_rdata));
    orc_link_checker u_chk (.sys_clk(sys_clk), .rst(rst), .req(link_bus.req), .wr(link_bus.wr),
        .page(link_bus.page), .cmd(link_bus.cmd), .wdata(link_bus.wdata), .ack(link_bus.ack),
        .nack(link_bus.nack), .rdata(link_bus.rdata));

    always #20 sys_clk = ~sys_clk;

    //----------------------------------------------------------------
    // Tasks
    //----------------------------------------------------------------
    task automatic report_and_stop();
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One user transfer; ends on done or on a refused value
    task automatic op(input logic w, input int p, input logic [7:0] c, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (usr_busy !== 1'b0 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        usr_start = 1'b1;
        usr_wr = w;
        usr_page = ORC_PAGE_W'(p);
        usr_cmd = c;
        usr_wdata = d;
        @(negedge sys_clk);
        usr_start = 1'b0;
        while (usr_done !== 1'b1 && usr_reject !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 50) begin
            err_count++;
            report_and_stop();
        end
        got_data = usr_rdata;
        got_err = usr_err;
        got_rej = usr_reject;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
    endtask

    function automatic logic [3:0] beh(input logic [7:0] m, input logic [31:0] lc);
        if (m == ORC_MODE_MAX_PWR) begin
            return {1'b0, 1'b1, lc[ORC_LC_APD_BIT], lc[ORC_LC_DE_PWR_BIT]};
        end
        return {1'b1, 1'b0, 1'b1, lc[ORC_LC_DE_EFF_BIT] | (m == ORC_MODE_MFR && lc[ORC_LC_DE_PWR_BIT])};
    endfunction

    function automatic logic [15:0] obs(input int p);
        return {12'h0, down_decay[p], down_toff_ctrl[p], phase_drop_en[p], diode_emul_en[p]};
    endfunction

    //----------------------------------------------------------------
    // Main sequence
    //----------------------------------------------------------------
    initial begin
        do_reset();
        for (int p = 0; p < ORC_PAGES; p++) begin
            for (int i = 0; i < 7; i++) begin
                op(1'b0, p, cmds[i], 16'h0000);
                chk(got_data, rstv[i]);
            end
            chk({14'h0, down_toff_ctrl[p], down_decay[p]}, 16'h0002);
        end
        for (int i = 0; i < 9; i++) begin
            op(1'b1, 0, wc[i], wd[i]);
            chk({15'h0, got_rej}, {15'h0, wj[i]});
            last = wj[i] ? last : wd[i];
            op(1'b0, 0, wc[i], 16'h0000);
            chk(got_data, last);
        end
        op(1'b1, 1, ORC_CMD_SLEW, 16'h0001);
        op(1'b1, 0, ORC_CMD_DROOP, 16'h1234);
        op(1'b0, 1, ORC_CMD_SLEW, 16'h0000);
        chk(got_data, 16'h0001);
        chk(slew_rate_out[0], 16'h2710);
        chk(slew_rate_out[1], 16'h0001);
        chk(droop_out[0], 16'h1234);
        chk(pwm_freq_out[0], 16'h00C8);
        chk(pwm_freq_out[1], ORC_RST_FREQ);
        vout_target = {16'h0100, 16'h0200};
        repeat (2) @(negedge sys_clk);
        chk(vout_regulated[0], 16'h0BEA);
        chk(vout_regulated[1], 16'h0100);
        vout_target[0] = 16'h0BEB;
        repeat (2) @(negedge sys_clk);
        chk(vout_regulated[0], 16'h0BEB);
        for (int i = 0; i < 4; i++) begin
            op(1'b1, 0, ORC_CMD_MODE, {8'h00, modes[i]});
            op(1'b0, 0, ORC_CMD_MODE, 16'h0000);
            chk(got_data, {8'h00, modes[i]});
            for (int j = 0; j < 4; j++) begin
                loop_config = {lcs[j], lcs[j]};
                @(negedge sys_clk);
                chk(obs(0), {12'h0, beh(bmode[i], lcs[j])});
                chk(obs(1), {12'h0, beh(ORC_MODE_MAX_PWR, lcs[j])});
            end
        end
        op(1'b1, 1, ORC_CMD_INPUT_TURN_ON_THRESHOLD, 16'hFF38);
        op(1'b1, 1, ORC_CMD_INPUT_TURN_OFF_THRESHOLD, 16'hFE70);
        for (int i = 0; i < 7; i++) begin
            vin_meas[vp[i]] = vv[i];
            repeat (2) @(negedge sys_clk);
            chk({15'h0, vin_ok[vp[i]]}, {15'h0, ve[i]});
        end
        op(1'b0, 0, 8'h29, 16'h0000);
        chk({15'h0, got_err}, 16'h0001);
        op(1'b1, 1, 8'h30, 16'h5555);
        chk({15'h0, got_err}, 16'h0001);
        op(1'b1, 0, ORC_CMD_MODE, 16'h0000);
        do_reset();
        op(1'b0, 0, ORC_CMD_SLEW, 16'h0000);
        chk(got_data, ORC_RST_SLEW);
        chk({15'h0, down_toff_ctrl[0]}, 16'h0001);
        op(1'b0, 0, ORC_CMD_MODE, 16'h0000);
        chk(got_data, {8'h00, ORC_RST_MODE});
        report_and_stop();
    end
endmodule // tb
